// ===== verilog/mmc_top.sv
// Purpose: mode register, resource base registers and address decode
// Assumes: APB3 slave, zero wait states; strap pins stable at reset release
// Notes: decode of base registers lags writes by two cycles
// Operation
// R01 - strap pins latched into mode bits at reset
// R02 - mode bits written under special/normal limits
// R03 - stretch enable selects stretched or free E clock
// R04 - stretch enable forced in expanded modes
// R05 - visibility drives internal cycles onto external bus
// R06 - visibility ignored normal narrow; write limits
// R07 - external bus stops in wait after delay
// R08 - port E emulation unmaps port E registers
// R09 - register block base, reset zero, 2K steps
// R10 - mapping interface stops in wait mode
// R11 - RAM base relocatable on 2K boundaries
// R12 - EEPROM base relocatable on 4K boundaries
// R13 - EEPROM enable gates reads; forced single-chip
// R14 - narrow bit makes following space 8-bit
// R15 - following space stretch count 0 to 3
// R16 - external space stretch count 0 to 3
// R17 - map bit selects program memory half
// R18 - program memory reset values follow mode
// R19 - other resources override program memory
// R20 - mode register unmapped in peripheral mode
// R21 - base writes take effect two cycles later
// R22 - decode priority bdm reg ram ee prog ext
// R23 - strap code selects operating mode
`timescale 1ns/1ps
`include "mmc_params.svh"
module mmc_top
  import mmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic background_pin,
  input wire logic mode_select_b,
  input wire logic mode_select_a,
  input wire logic wait_mode,
  input wire logic bdm_active,
  input wire logic [15:0] cpu_addr,
  output mmc_mode_t op_mode,
  output mmc_hit_t cpu_hit,
  output logic follow_space,
  output logic follow_narrow,
  output logic [1:0] stretch_count,
  output logic eclk_stretch_enable,
  output logic internal_visibility,
  output logic visible_wide,
  output logic port_e_regs_mapped,
  output logic ext_bus_shutdown,
  output logic map_iface_shutdown
);
  localparam int EBUS_STOP_CYC_I = (`MMC_EBUS_STOP_NS + `MMC_CLK_NS - 1) / `MMC_CLK_NS;
  localparam logic [7:0] EBUS_STOP_CYC = EBUS_STOP_CYC_I[7:0];

  function automatic logic is_expanded(input mmc_mode_t m);
    is_expanded = (m == mmc_spec_narrow) || (m == mmc_spec_wide) || (m == mmc_norm_narrow) || (m == mmc_norm_wide);
  endfunction

  function automatic logic is_single(input mmc_mode_t m);
    is_single = (m == mmc_spec_single) || (m == mmc_norm_single);
  endfunction

  function automatic mmc_mode_t code_to_mode(input logic [2:0] c);
    // reserved code 110 behaves as peripheral
    code_to_mode = (c == 3'h6) ? mmc_spec_periph : mmc_mode_t'(c);
  endfunction

  logic init_done_q;
  logic [7:0] mode_q;
  logic [7:0] misc_q;
  logic [7:0] regbase_q, rambase_q, eebase_q;
  logic [7:0] regbase_p1_q, rambase_p1_q, eebase_p1_q;
  logic [7:0] regbase_eff_q, rambase_eff_q, eebase_eff_q;
  logic mode_wr_q, misc_wr_q, regbase_wr_q, rambase_wr_q, eebase_wr_q;
  logic [31:0] prdata_q;
  logic [7:0] stop_cnt_q;

  mmc_mode_t cur_mode;
  logic special;
  logic expanded;
  logic [5:0] idx;
  logic idx_mapped;
  logic wr_en;
  logic [7:0] wb;

  assign cur_mode = code_to_mode(mode_q[7:5]);
  assign special = ~mode_q[`MMC_MODE_SPECIAL_MODE_N];
  assign expanded = is_expanded(cur_mode);
  assign idx = paddr[7:2];
  assign wb = pwdata[7:0];

  always_comb begin
    idx_mapped = 1'b0;
    if (paddr[1:0] == 2'h0) begin
      case (idx)
        `MMC_IDX_MODE: idx_mapped = (cur_mode != mmc_spec_periph); // R20
        `MMC_IDX_MISC, `MMC_IDX_REGBASE, `MMC_IDX_RAMBASE, `MMC_IDX_EEBASE: idx_mapped = 1'b1;
        default: idx_mapped = 1'b0;
      endcase
    end
  end

  // slave waits until the strap capture has loaded the mode-dependent values
  assign pready = init_done_q;
  assign pslverr = psel & penable & ~idx_mapped;
  assign prdata = prdata_q;
  assign wr_en = psel & penable & pready & pwrite & idx_mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  // mode register: strap capture on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 8'h00;
      mode_wr_q <= 1'b0;
    end else if (!init_done_q) begin
      mode_q <= 8'h00;
      mode_q[7:5] <= {background_pin, mode_select_b, mode_select_a}; // R01 R23
      mode_q[`MMC_MODE_ECLK_STRETCH_ENABLE] <= 1'b1;
      mode_q[`MMC_MODE_INTERNAL_VISIBILITY] <= ~background_pin;
      mode_q[`MMC_MODE_EME] <= ~background_pin;
      if ({background_pin, mode_select_b, mode_select_a} == 3'h6) begin
        mode_q[`MMC_MODE_SPECIAL_MODE_N] <= 1'b0;
      end
    end else if (wr_en && idx == `MMC_IDX_MODE) begin
      mode_wr_q <= 1'b1;
      // special-mode bit can only move to 1, and never on the first write
      if (special && mode_wr_q) begin
        mode_q[`MMC_MODE_SPECIAL_MODE_N] <= wb[`MMC_MODE_SPECIAL_MODE_N]; // R02
      end
      // peripheral and reserved codes have b=1,a=0 and are refused
      if ((special || !mode_wr_q) && !(wb[`MMC_MODE_MODE_SELECT_B] && !wb[`MMC_MODE_MODE_SELECT_A])) begin
        mode_q[`MMC_MODE_MODE_SELECT_B] <= wb[`MMC_MODE_MODE_SELECT_B]; // R02
        mode_q[`MMC_MODE_MODE_SELECT_A] <= wb[`MMC_MODE_MODE_SELECT_A]; // R02
      end
      if (special || !mode_wr_q) begin
        mode_q[`MMC_MODE_ECLK_STRETCH_ENABLE] <= wb[`MMC_MODE_ECLK_STRETCH_ENABLE]; // R04
      end
      if (special ? mode_wr_q : !mode_wr_q) begin
        mode_q[`MMC_MODE_INTERNAL_VISIBILITY] <= wb[`MMC_MODE_INTERNAL_VISIBILITY]; // R06
        mode_q[`MMC_MODE_EME] <= wb[`MMC_MODE_EME]; // R08
      end
      if (!special) begin
        mode_q[`MMC_MODE_EXT_BUS_WAIT_STOP] <= wb[`MMC_MODE_EXT_BUS_WAIT_STOP]; // R07
      end
    end else if (expanded) begin
      mode_q[`MMC_MODE_ECLK_STRETCH_ENABLE] <= 1'b1; // R04
    end
  end

  // misc register: program memory placement and stretch codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_q <= `MMC_RST_MISC_EXP;
      misc_wr_q <= 1'b0;
    end else if (!init_done_q) begin
      // peripheral takes the expanded values; only the single-chip codes set the program memory enable and upper-half bits
      misc_q <= is_single(code_to_mode({background_pin, mode_select_b, mode_select_a})) ?
                `MMC_RST_MISC_SC : `MMC_RST_MISC_EXP; // R18
    end else if (wr_en && idx == `MMC_IDX_MISC && (special || !misc_wr_q)) begin
      misc_wr_q <= 1'b1;
      misc_q <= {1'b0, wb[6:0]};
    end
  end

  // base registers: shadow values as software sees them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regbase_q <= `MMC_RST_REGBASE;
      rambase_q <= `MMC_RST_RAMBASE;
      eebase_q <= `MMC_RST_EEBASE;
      regbase_wr_q <= 1'b0;
      rambase_wr_q <= 1'b0;
      eebase_wr_q <= 1'b0;
    end else if (wr_en) begin
      case (idx)
        `MMC_IDX_REGBASE: begin
          regbase_wr_q <= 1'b1;
          if (special || !regbase_wr_q) begin
            regbase_q[7:3] <= wb[7:3]; // R09
          end
          if (!special) begin
            regbase_q[`MMC_RG_MAP_IFACE_WAIT_STOP] <= wb[`MMC_RG_MAP_IFACE_WAIT_STOP]; // R10
          end
        end
        `MMC_IDX_RAMBASE: begin
          rambase_wr_q <= 1'b1;
          if (special || !rambase_wr_q) begin
            rambase_q[7:3] <= wb[7:3]; // R11
          end
        end
        `MMC_IDX_EEBASE: begin
          eebase_wr_q <= 1'b1;
          if (special || !eebase_wr_q) begin
            eebase_q[7:4] <= wb[7:4]; // R12
          end
          if (!is_single(cur_mode)) begin
            eebase_q[`MMC_EE_EEPROM_READ_ENABLE] <= wb[`MMC_EE_EEPROM_READ_ENABLE]; // R13
          end
        end
        default: begin
        end
      endcase
    end else if (is_single(cur_mode) && init_done_q) begin
      eebase_q[`MMC_EE_EEPROM_READ_ENABLE] <= 1'b1; // R13
    end
  end

  // two-stage lag before the decoder sees a new base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regbase_p1_q <= `MMC_RST_REGBASE;
      rambase_p1_q <= `MMC_RST_RAMBASE;
      eebase_p1_q <= `MMC_RST_EEBASE;
      regbase_eff_q <= `MMC_RST_REGBASE;
      rambase_eff_q <= `MMC_RST_RAMBASE;
      eebase_eff_q <= `MMC_RST_EEBASE;
    end else begin
      regbase_p1_q <= regbase_q; // R21
      rambase_p1_q <= rambase_q; // R21
      eebase_p1_q <= eebase_q; // R21
      regbase_eff_q <= regbase_p1_q;
      rambase_eff_q <= rambase_p1_q;
      eebase_eff_q <= eebase_p1_q;
    end
  end

  // read data captured in the setup phase so it is a flop at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= 32'h0000_0000;
      if (paddr[1:0] == 2'h0) begin
        case (idx)
          `MMC_IDX_MODE: prdata_q[7:0] <= (cur_mode != mmc_spec_periph) ? {mode_q[7:2], 1'b0, mode_q[0]} : 8'h00;
          `MMC_IDX_MISC: prdata_q[7:0] <= misc_q;
          `MMC_IDX_REGBASE: prdata_q[7:0] <= {regbase_q[7:3], 2'h0, regbase_q[0]};
          `MMC_IDX_RAMBASE: prdata_q[7:0] <= {rambase_q[7:3], 3'h0};
          `MMC_IDX_EEBASE: prdata_q[7:0] <= {eebase_q[7:4], 3'h0, eebase_q[0]};
          default: prdata_q[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // wait-mode shutdown of the external bus after the drain delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_cnt_q <= 8'h00;
    end else if (!(wait_mode && mode_q[`MMC_MODE_EXT_BUS_WAIT_STOP])) begin
      stop_cnt_q <= 8'h00;
    end else if (stop_cnt_q != EBUS_STOP_CYC) begin
      stop_cnt_q <= stop_cnt_q + 8'h01; // R07
    end
  end

  assign ext_bus_shutdown = (stop_cnt_q == EBUS_STOP_CYC); // R07
  assign map_iface_shutdown = wait_mode & regbase_q[`MMC_RG_MAP_IFACE_WAIT_STOP]; // R10
  assign op_mode = cur_mode;
  assign eclk_stretch_enable = mode_q[`MMC_MODE_ECLK_STRETCH_ENABLE]; // R03
  // normal narrow never shows internal cycles
  assign internal_visibility = mode_q[`MMC_MODE_INTERNAL_VISIBILITY] & expanded & (cur_mode != mmc_norm_narrow); // R05 R06
  assign visible_wide = internal_visibility; // R05
  assign port_e_regs_mapped = ~(expanded & mode_q[`MMC_MODE_EME]); // R08

  logic in_reg, in_follow, in_ram, in_ee, in_prog, in_bdm;
  always_comb begin
    in_bdm = bdm_active && (cpu_addr >= `MMC_BDM_START);
    in_reg = (cpu_addr[15:11] == regbase_eff_q[7:3]) && (cpu_addr[10:9] == 2'h0); // R09
    in_follow = (cpu_addr[15:11] == regbase_eff_q[7:3]) && (cpu_addr[10:9] == 2'h1); // R14
    in_ram = (cpu_addr[15:11] == rambase_eff_q[7:3]) && !cpu_addr[10]; // R11
    in_ee = eebase_eff_q[`MMC_EE_EEPROM_READ_ENABLE] && (cpu_addr[15:12] == eebase_eff_q[7:4]) &&
            (cpu_addr[11:0] >= `MMC_EE_START); // R12 R13
    in_prog = misc_q[`MMC_MISC_PROGMEM_ENABLE] && (cpu_addr[15] == misc_q[`MMC_MISC_PROGMEM_UPPER_HALF]); // R17
    if (in_bdm) begin
      cpu_hit = mmc_hit_bdm; // R22
    end else if (in_reg) begin
      cpu_hit = mmc_hit_reg; // R22
    end else if (in_ram) begin
      cpu_hit = mmc_hit_ram; // R19
    end else if (in_ee) begin
      cpu_hit = mmc_hit_eeprom; // R19
    end else if (in_prog) begin
      cpu_hit = mmc_hit_progmem;
    end else if (expanded) begin
      cpu_hit = mmc_hit_external;
    end else begin
      cpu_hit = mmc_hit_none;
    end
  end

  // stretch and narrow codes only count for external cycles in expanded modes
  always_comb begin
    follow_space = (cpu_hit == mmc_hit_external) && in_follow;
    follow_narrow = follow_space && mode_q[`MMC_MISC_FOLLOW_SPACE_NARROW - 1] == 1'b1 && misc_q[`MMC_MISC_FOLLOW_SPACE_NARROW] &&
                    ((cur_mode == mmc_spec_wide) || (cur_mode == mmc_norm_wide)); // R14
    if (cpu_hit != mmc_hit_external) begin
      stretch_count = 2'h0;
    end else if (follow_space) begin
      stretch_count = misc_q[`MMC_MISC_RF_LO +: 2]; // R15
    end else begin
      stretch_count = misc_q[`MMC_MISC_EX_LO +: 2]; // R16
    end
  end
endmodule

// ===== common/mmc_params.svh
// Purpose: constants for the mode and memory map control block
// Assumes: indices are word indices; byte address is four times the index
// Notes: reset values of the mode register depend on the latched mode
`ifndef MMC_PARAMS_SVH
`define MMC_PARAMS_SVH
`define MMC_IDX_MODE 6'h0B
`define MMC_IDX_MISC 6'h13
`define MMC_IDX_REGBASE 6'h14
`define MMC_IDX_RAMBASE 6'h15
`define MMC_IDX_EEBASE 6'h16
`define MMC_MODE_SPECIAL_MODE_N 7
`define MMC_MODE_MODE_SELECT_B 6
`define MMC_MODE_MODE_SELECT_A 5
`define MMC_MODE_ECLK_STRETCH_ENABLE 4
`define MMC_MODE_INTERNAL_VISIBILITY 3
`define MMC_MODE_EXT_BUS_WAIT_STOP 2
`define MMC_MODE_EME 0
`define MMC_MISC_FOLLOW_SPACE_NARROW 6
`define MMC_MISC_RF_LO 4
`define MMC_MISC_EX_LO 2
`define MMC_MISC_PROGMEM_UPPER_HALF 1
`define MMC_MISC_PROGMEM_ENABLE 0
`define MMC_BASE5_LO 3
`define MMC_EE_BASE_LO 4
`define MMC_EE_EEPROM_READ_ENABLE 0
`define MMC_RG_MAP_IFACE_WAIT_STOP 0
`define MMC_RST_REGBASE 8'h00
`define MMC_RST_RAMBASE 8'h08
`define MMC_RST_EEBASE 8'h01
`define MMC_RST_MISC_EXP 8'h0C
`define MMC_RST_MISC_SC 8'h0F
`define MMC_EE_START 12'hD00
`define MMC_BDM_START 16'hFF00
`define MMC_EBUS_STOP_NS 20
`define MMC_CLK_NS 5
`endif

// ===== common/mmc_pkg.sv
// Purpose: types for the mode and memory map control block
// Assumes: nothing
// Notes: mode order follows the three strap bits
package mmc_pkg;
  typedef enum logic [2:0] {
    mmc_spec_single, mmc_spec_narrow, mmc_spec_periph, mmc_spec_wide,
    mmc_norm_single, mmc_norm_narrow, mmc_norm_periph, mmc_norm_wide
  } mmc_mode_t;
  typedef enum logic [2:0] {
    mmc_hit_none, mmc_hit_bdm, mmc_hit_reg, mmc_hit_ram, mmc_hit_eeprom, mmc_hit_progmem, mmc_hit_external
  } mmc_hit_t;
endpackage

// ===== bench/mmc_chk.sv
// Purpose: port-level checks for the mode and map control block
// Assumes: single clock domain, active low async reset
// Notes: bound to the top module; watches bus and processor inputs as well as outputs
`timescale 1ns/1ps
module mmc_chk
  import mmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wait_mode,
  input wire logic bdm_active,
  input wire logic [15:0] cpu_addr,
  input wire mmc_mode_t op_mode,
  input wire mmc_hit_t cpu_hit,
  input wire logic [1:0] stretch_count,
  input wire logic eclk_stretch_enable,
  input wire logic internal_visibility,
  input wire logic port_e_regs_mapped,
  input wire logic ext_bus_shutdown,
  input wire logic map_iface_shutdown
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_mode_unmapped: assert property (
    psel && penable && pready && op_mode == mmc_spec_periph && paddr == 8'h2C |-> pslverr)
    else $error("mode register answered in peripheral mode");
  a_bus_stop_delay: assert property (
    $rose(ext_bus_shutdown) |-> $past(wait_mode, 3) && wait_mode)
    else $error("bus shut down without the wait delay");
  a_bus_stop_release: assert property (
    !wait_mode |-> ##[0:1] !ext_bus_shutdown)
    else $error("bus still shut down after wait ended");
  a_map_stop_wait: assert property (
    map_iface_shutdown |-> wait_mode)
    else $error("map interface stopped outside wait");
  a_bdm_first: assert property (
    bdm_active && cpu_addr >= 16'hFF00 |-> cpu_hit == mmc_hit_bdm)
    else $error("debug rom lost priority");
  a_stretch_internal: assert property (
    cpu_hit != mmc_hit_external |-> stretch_count == 2'h0)
    else $error("internal access stretched");
  a_narrow_no_vis: assert property (
    op_mode == mmc_norm_narrow |-> !internal_visibility)
    else $error("visibility active in normal narrow");
  a_port_e_data_reg_single: assert property (
    op_mode == mmc_spec_single || op_mode == mmc_norm_single |-> port_e_regs_mapped)
    else $error("port e registers unmapped in single chip");
  a_eclk_stretch_enable_expanded: assert property (
    op_mode[0] |-> eclk_stretch_enable)
    else $error("stretch enable low in expanded mode");
endmodule

bind mmc_top mmc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .wait_mode(wait_mode), .bdm_active(bdm_active),
  .cpu_addr(cpu_addr), .op_mode(op_mode), .cpu_hit(cpu_hit), .stretch_count(stretch_count),
  .eclk_stretch_enable(eclk_stretch_enable), .internal_visibility(internal_visibility),
  .port_e_regs_mapped(port_e_regs_mapped), .ext_bus_shutdown(ext_bus_shutdown),
  .map_iface_shutdown(map_iface_shutdown));

// ===== bench/mmc_cpu_model.sv
// Purpose: processor side stand-in presenting addresses to the decoder
// Assumes: one address per call, held until the next call
// Notes: wait and debug levels travel with each access
`timescale 1ns/1ps
module mmc_cpu_model (
  input wire logic pclk,
  output logic [15:0] cpu_addr,
  output logic bdm_active,
  output logic wait_mode
);
  initial begin
    cpu_addr = 16'h0000;
    bdm_active = 1'h0;
    wait_mode = 1'h0;
  end
  // decode is combinational, so one edge of hold is enough to sample
  task automatic access(input logic [15:0] a, input logic b, input logic w);
    @(posedge pclk);
    cpu_addr <= a;
    bdm_active <= b;
    wait_mode <= w;
    @(posedge pclk);
  endtask
endmodule

// ===== bench/mmc_tb_top.sv
// Purpose: self-checking bench for the mode and map control block
// Assumes: zero wait APB slave, straps set before reset release
// Notes: each strap code is visited through its own reset
`timescale 1ns/1ps
`include "mmc_params.svh"
module mmc_tb_top import mmc_pkg::*;;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic background_pin = 1'h1, mode_select_b = 1'h1, mode_select_a = 1'h1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, wait_mode, bdm_active, follow_space, eclk_stretch_enable;
  logic ext_bus_shutdown, map_iface_shutdown;
  logic [15:0] cpu_addr;
  logic [1:0] stretch_count;
  logic [2:0] s;
  mmc_mode_t op_mode;
  mmc_hit_t cpu_hit;
  int n_fail = 0, total_checks = 0;
  initial forever #2.5 pclk = ~pclk;
  mmc_cpu_model cpu (.pclk(pclk), .cpu_addr(cpu_addr), .bdm_active(bdm_active), .wait_mode(wait_mode));
  mmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .background_pin(background_pin), .mode_select_b(mode_select_b), .mode_select_a(mode_select_a),
    .wait_mode(wait_mode), .bdm_active(bdm_active), .cpu_addr(cpu_addr), .op_mode(op_mode),
    .cpu_hit(cpu_hit), .follow_space(follow_space), .follow_narrow(), .stretch_count(stretch_count),
    .eclk_stretch_enable(eclk_stretch_enable), .internal_visibility(), .visible_wide(),
    .port_e_regs_mapped(), .ext_bus_shutdown(ext_bus_shutdown), .map_iface_shutdown(map_iface_shutdown));
  task automatic end_of_test();
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp, input logic exp_err);
    apb(1'h0, idx, 8'h00);
    chk("prdata", {24'h0, exp}, rd);
    chk("pslverr", {31'h0, exp_err}, {31'h0, err});
  endtask
  task automatic hit(input logic [15:0] a, input logic b, input mmc_hit_t exp);
    cpu.access(a, b, 1'h0);
    chk("cpu_hit", {29'h0, exp}, {29'h0, cpu_hit});
  endtask
  task automatic do_reset(input logic [2:0] code);
    @(posedge pclk);
    presetn <= 1'h0;
    {background_pin, mode_select_b, mode_select_a} <= code;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    for (int c = 0; c < 8; c++) begin
      s = c[2:0];
      do_reset(s);
      rdc(`MMC_IDX_MODE, (s == 3'h2 || s == 3'h6) ? 8'h00 : {s, 1'h1, ~s[2], 2'h0, ~s[2]}, s[1:0] == 2'h2);
      chk("op_mode", (s == 3'h6) ? 32'h2 : {29'h0, s}, {29'h0, op_mode});
      rdc(`MMC_IDX_MISC, (s[1:0] == 2'h0) ? 8'h0F : 8'h0C, 1'h0);
      rdc(`MMC_IDX_REGBASE, 8'h00, 1'h0);
      rdc(`MMC_IDX_RAMBASE, 8'h08, 1'h0);
      rdc(`MMC_IDX_EEBASE, 8'h01, 1'h0);
      hit(16'h0000, 1'h0, mmc_hit_reg);
    end
    apb(1'h1, `MMC_IDX_RAMBASE, 8'h10);
    apb(1'h1, `MMC_IDX_RAMBASE, 8'h20);
    rdc(`MMC_IDX_RAMBASE, 8'h10, 1'h0);
    hit(16'h1000, 1'h0, mmc_hit_ram);
    hit(16'h0800, 1'h0, mmc_hit_external);
    chk("stretch_count", 32'h3, {30'h0, stretch_count});
    apb(1'h1, `MMC_IDX_MISC, 8'h24);
    apb(1'h1, `MMC_IDX_MISC, 8'h0C);
    rdc(`MMC_IDX_MISC, 8'h24, 1'h0);
    hit(16'h0200, 1'h0, mmc_hit_external);
    chk("follow_space", 32'h1, {31'h0, follow_space});
    chk("stretch_count", 32'h2, {30'h0, stretch_count});
    hit(16'h4000, 1'h0, mmc_hit_external);
    chk("stretch_count", 32'h1, {30'h0, stretch_count});
    rdc(6'h3F, 8'h00, 1'h1);
    apb(1'h1, `MMC_IDX_MODE, 8'hF4);
    apb(1'h1, `MMC_IDX_REGBASE, 8'h01);
    rdc(`MMC_IDX_MODE, 8'hF4, 1'h0);
    cpu.access(16'h4000, 1'h0, 1'h1);
    repeat (6) @(posedge pclk);
    chk("shutdown", 32'h3, {30'h0, ext_bus_shutdown, map_iface_shutdown});
    cpu.access(16'h4000, 1'h0, 1'h0);
    do_reset(3'h0);
    apb(1'h1, `MMC_IDX_REGBASE, 8'h80);
    apb(1'h1, `MMC_IDX_REGBASE, 8'h88);
    rdc(`MMC_IDX_REGBASE, 8'h88, 1'h0);
    hit(16'h8800, 1'h0, mmc_hit_reg);
    hit(16'h8A00, 1'h0, mmc_hit_progmem);
    hit(16'hFF10, 1'h1, mmc_hit_bdm);
    hit(16'h0D00, 1'h0, mmc_hit_eeprom);
    apb(1'h1, `MMC_IDX_MISC, 8'h0D);
    hit(16'h1000, 1'h0, mmc_hit_progmem);
    apb(1'h1, `MMC_IDX_MODE, 8'h1D);
    rdc(`MMC_IDX_MODE, 8'h19, 1'h0);
    end_of_test();
  end
endmodule
